// ==== dv/nsoc_monitor.sv ====
/* Port checker for nsoc_top.
   Bound from the bench; one clock domain. */
`timescale 1ns/1ns
module nsoc_monitor
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        O_WB_ACK,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        I_SAMPLE_EN,
  input wire logic        I_DISABLE,
  input wire logic        O_START,
  input wire logic        O_TRIP
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_B);
  property p_ack; O_WB_ACK |=> !O_WB_ACK; endproperty
  a_ack: assert property (p_ack) else $error("ack held");
  property p_lat; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
  a_lat: assert property (p_lat) else $error("ack late");
  property p_dat; !O_WB_ACK |-> O_WB_DAT == 32'h0000_0000; endproperty
  a_dat: assert property (p_dat) else $error("data without ack");
  property p_dis_st; I_DISABLE |=> !O_START; endproperty
  a_dis_st: assert property (p_dis_st) else $error("start");
  property p_dis_tr; I_DISABLE |=> !O_TRIP; endproperty
  a_dis_tr: assert property (p_dis_tr) else $error("trip");
  property p_pair; O_TRIP |-> O_START; endproperty
  a_pair: assert property (p_pair) else $error("lone trip");
  // Pickup is judged only on a sample strobe
  property p_src;
    $rose(O_START) |-> $past(I_SAMPLE_EN, 2) || $past(I_SAMPLE_EN);
  endproperty
  a_src: assert property (p_src) else $error("stray start");
  property p_tr_up; $rose(O_TRIP) |-> O_START && !$past(I_DISABLE); endproperty
  a_tr_up: assert property (p_tr_up) else $error("bad trip");
  c_trip: cover property ($rose(O_TRIP));
  c_drop: cover property ($fell(O_START));
  c_dis: cover property (O_START ##1 I_DISABLE);
endmodule

// ==== dv/nsoc_phase_src.sv ====
/* Phase source: one strobe every SPACING clocks, phase a only.
   Assumes the bench holds i_amp steady between strobes. */
`timescale 1ns/1ns
module nsoc_phase_src
  import nsoc_pkg::*;
#(
  parameter int SPACING = 200
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_amp,
  output logic             o_sample_en,
  output nsoc_phases_s     o_phases
);
  int cnt;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt <= 0;
      o_sample_en <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == SPACING - 1) ? 0 : cnt + 1;
      o_sample_en <= (cnt == SPACING - 1);
    end
  end
  // Single loaded phase: negative sequence is a third of it
  assign o_phases = {i_amp, 80'h0};
endmodule

// ==== dv/tb_top.sv ====
/* Bench for nsoc_top: registers, off, fixed, irq, disable, inverse.
   Assumes 1 ms shortened to 100 clocks, samples every 2 ms. */
`timescale 1ns/1ns
`include "nsoc_map.svh"
module tb_top
  import nsoc_pkg::*;
;
  localparam int MS = 100;
  localparam int T_EI = 80000 * MS / 399;
  localparam int T_LO = T_EI * 95 / 100, T_HI = T_EI * 105 / 100 + 300;
  logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, dis = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic        ack, start, trip, irq, sen;
  logic [15:0] amp = 16'h0000;
  nsoc_phases_s ph;
  int          num_errors = 0, cmp_count = 0, ticks = 0, n;
  nsoc_top #(.MS_CYCLES(MS), .SAMPLE_US(2000)) uut
  (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SAMPLE_EN(sen), .I_PHASES(ph),
    .I_DISABLE(dis), .O_START(start), .O_TRIP(trip), .O_IRQ(irq)
  );
  nsoc_phase_src src
  (
    .i_clk(clk), .i_rst_b(rst_b), .i_amp(amp), .o_sample_en(sen),
    .o_phases(ph)
  );
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= 32'(d);
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_out(input logic on_trip, input int lim);
    n = 0;
    while ((on_trip ? trip : start) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic s_regs;
    for (int i = 0; i < 10; i++)
    begin
      wb(1'b0, 8'(4 * i), 0);
      chk(q, i == 1 ? 50 : (i > 1 && i < 6) ? 100 : 0);
    end
    wb(1'b1, `NSOC_REG_START, 300);
    wb(1'b0, `NSOC_REG_START, 0);
    chk(q, 32'(`NSOC_PCT_MAX));
    wb(1'b1, `NSOC_REG_START, 50);
    amp <= 16'h7530;
    repeat (600) @(posedge clk);
    chk(32'(start), 0);
  endtask
  task automatic s_fixed;
    wb(1'b1, `NSOC_REG_IRQ_MSK, 3);
    wb(1'b1, `NSOC_REG_DEFDLY, 3);
    wb(1'b1, `NSOC_REG_CTRL, MODE_FIXED_DELAY);
    wait_out(1'b0, 400);
    chk(32'(n < 205), 1);
    wait_out(1'b1, 400);
    chk(32'(n > 194 && n < 306), 1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 1);
    wb(1'b0, `NSOC_REG_IRQ_ST, 0);
    chk(q, 3);
    wb(1'b1, `NSOC_REG_IRQ_ST, 3);
    wb(1'b0, `NSOC_REG_IRQ_ST, 0);
    chk(q + 32'(irq), 0);
    dis <= 1'b1;
    wb(1'b1, `NSOC_REG_IRQ_MSK, 0);
    chk(32'({start, trip}), 0);
    dis <= 1'b0;
    wait_out(1'b0, 400);
    wb(1'b0, `NSOC_REG_IRQ_ST, 0);
    chk(q + 32'(irq), 1);
    amp <= 16'h0258;
    repeat (450) @(posedge clk);
    chk(32'({start, trip}), 0);
  endtask
  task automatic s_inv;
    // Ratio above the range limit must time as if at exactly twenty
    wb(1'b1, `NSOC_REG_CTRL, MODE_IEC_EI);
    amp <= 16'h7FBC;
    wait_out(1'b1, 30000);
    chk(32'(n > T_LO && n < T_HI), 1);
    wb(1'b1, `NSOC_REG_MINDLY, 300);
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    wait_out(1'b1, 35000);
    chk(32'(n > 29700 && n < 30600), 1);
    // Timing survives a short drop-off, not one past the reset delay
    wb(1'b1, `NSOC_REG_MINDLY, 0);
    amp <= 16'h0258;
    repeat (2000) @(posedge clk);
    amp <= 16'h7FBC;
    wait_out(1'b1, 1000);
    chk(32'(n < 500), 1);
    amp <= 16'h0258;
    repeat (12000) @(posedge clk);
    amp <= 16'h7FBC;
    wait_out(1'b1, 5000);
    chk(32'(trip), 0);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 90000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    s_regs();
    s_fixed();
    s_inv();
    print_verdict();
  end
endmodule
bind nsoc_top nsoc_monitor u_mon
(
  .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT),
  .I_SAMPLE_EN(I_SAMPLE_EN), .I_DISABLE(I_DISABLE), .O_START(O_START),
  .O_TRIP(O_TRIP)
);

// ==== logic/nsoc_map.svh ====
/*
  Register map, field positions, reset values and timing counts of the
  negative sequence overcurrent block.
  Assumes a 100 MHz core clock and 32-bit Wishbone byte addresses.
*/
`ifndef NSOC_MAP_SVH
`define NSOC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define NSOC_REG_CTRL     8'h00
`define NSOC_REG_START    8'h04
`define NSOC_REG_DEFDLY   8'h08
`define NSOC_REG_MINDLY   8'h0C
`define NSOC_REG_RSTDLY   8'h10
`define NSOC_REG_MULT     8'h14
`define NSOC_REG_IRQ_ST   8'h18
`define NSOC_REG_IRQ_MSK  8'h1C
`define NSOC_REG_STATE    8'h20

// ----------------------------------------------------------------------
// Field positions of status, mask and state registers
// ----------------------------------------------------------------------
`define NSOC_BIT_START    0
`define NSOC_BIT_TRIP     1

// ----------------------------------------------------------------------
// Reset values and setting ranges
// ----------------------------------------------------------------------
`define NSOC_PCT_RST      16'h0032
`define NSOC_PCT_MIN      16'h0005
`define NSOC_PCT_MAX      16'h00C8
`define NSOC_DLY_RST      16'h0064
`define NSOC_DLY_MAX      16'hEA60
`define NSOC_MULT_MIN     16'h0064
`define NSOC_MULT_MAX     16'hEA60
`define NSOC_MULT_RST     16'h0064
`define NSOC_MULT_UNIT    16'h0064

// ----------------------------------------------------------------------
// Timing and arithmetic constants
// ----------------------------------------------------------------------
`define NSOC_TICK_NS      1000000
`define NSOC_CLK_NS       10
`define NSOC_MS_CYCLES    (`NSOC_TICK_NS / `NSOC_CLK_NS)
`define NSOC_SAMPLE_US    1000
`define NSOC_US_PER_S     1000000
`define NSOC_PCT_CODE     10
`define NSOC_ACC_FRAC     24
`define NSOC_ACC_ONE      26'h100_0000
`define NSOC_INC_MAX      26'h200_0000
`define NSOC_ONE_Q16      25'h1_0000
`define NSOC_R2_CAP       25'h190_0000
`define NSOC_DROP_NUM     16'h0169
`define NSOC_DROP_DEN     16'h0190
`define NSOC_LN2_ALPHA    16'h01C6
`define NSOC_LOG_CORR     16'h000B

`endif

// ==== logic/nsoc_pkg.sv ====
/*
  Types of the negative sequence overcurrent block: modes, curve
  constants, phasor carriers and sequencer states.
  Assumes curve constants k and c are unsigned Q16 seconds.
*/
package nsoc_pkg;

  // --------------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF         = 4'h0,
    MODE_FIXED_DELAY = 4'h1,
    MODE_IEC_NI      = 4'h2,
    MODE_IEC_VI      = 4'h3,
    MODE_IEC_EI      = 4'h4,
    MODE_IEC_LI      = 4'h5,
    MODE_ANSI_NI     = 4'h6,
    MODE_ANSI_MI     = 4'h7,
    MODE_ANSI_VI     = 4'h8,
    MODE_ANSI_EI     = 4'h9,
    MODE_ANSI_LI     = 4'hA,
    MODE_ANSI_LVI    = 4'hB,
    MODE_ANSI_LEI    = 4'hC
  } nsoc_mode_e;

  typedef enum logic [1:0] {
    ALPHA_P02 = 2'h0,
    ALPHA_1   = 2'h1,
    ALPHA_2   = 2'h2
  } nsoc_alpha_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RATIO = 5'h02,
    ST_ROOT  = 5'h04,
    ST_CALC  = 5'h08,
    ST_INC   = 5'h10
  } nsoc_state_e;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [23:0] k;
    logic [15:0] c;
    nsoc_alpha_e alpha;
  } nsoc_curve_s;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } nsoc_phasor_s;

  typedef struct packed {
    nsoc_phasor_s a;
    nsoc_phasor_s b;
    nsoc_phasor_s c;
  } nsoc_phases_s;

  // Curve constants, k and c in Q16 seconds
  function automatic nsoc_curve_s nsoc_curve_of(input nsoc_mode_e m);
    case (m)
      MODE_IEC_NI:   nsoc_curve_of = '{24'h00_23D7, 16'h0000, ALPHA_P02};
      MODE_IEC_VI:   nsoc_curve_of = '{24'h0D_8000, 16'h0000, ALPHA_1};
      MODE_IEC_EI:   nsoc_curve_of = '{24'h50_0000, 16'h0000, ALPHA_2};
      MODE_IEC_LI:   nsoc_curve_of = '{24'h78_0000, 16'h0000, ALPHA_1};
      MODE_ANSI_NI:  nsoc_curve_of = '{24'h00_0234, 16'h04BC, ALPHA_P02};
      MODE_ANSI_MI:  nsoc_curve_of = '{24'h00_0D2F, 16'h1D2F, ALPHA_P02};
      MODE_ANSI_VI:  nsoc_curve_of = '{24'h13_9C29, 16'h7DB2, ALPHA_2};
      MODE_ANSI_EI:  nsoc_curve_of = '{24'h1C_3333, 16'h1F28, ALPHA_2};
      MODE_ANSI_LI:  nsoc_curve_of = '{24'h00_1604, 16'h2F5C, ALPHA_P02};
      MODE_ANSI_LVI: nsoc_curve_of = '{24'h1C_8CCD, 16'hB646, ALPHA_2};
      MODE_ANSI_LEI: nsoc_curve_of = '{24'h40_11EC, 16'h4000, ALPHA_2};
      default:       nsoc_curve_of = '{24'h00_23D7, 16'h0000, ALPHA_P02};
    endcase
  endfunction

endpackage

// ==== logic/nsoc_top.sv ====
/*
  Negative sequence overcurrent protection: pickup, definite and
  inverse time tripping, Wishbone register file and interrupt.
  Assumes phase Fourier components are valid whenever I_SAMPLE_EN
  pulses, and that they are RMS-scaled, PCT_CODE codes per 1 % of In.
*/
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "nsoc_map.svh"

module nsoc_top
  import nsoc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `NSOC_MS_CYCLES,
  parameter int unsigned SAMPLE_US = `NSOC_SAMPLE_US,
  parameter int unsigned PCT_CODE  = `NSOC_PCT_CODE
)
(
  input  wire logic         I_CORE_CLK,
  input  wire logic         I_RST_B,
  input  wire logic         I_WB_CYC,
  input  wire logic         I_WB_STB,
  input  wire logic         I_WB_WE,
  input  wire logic [7:0]   I_WB_ADR,
  input  wire logic [3:0]   I_WB_SEL,
  input  wire logic [31:0]  I_WB_DAT,
  output logic      [31:0]  O_WB_DAT,
  output logic              O_WB_ACK,
  input  wire logic         I_SAMPLE_EN,
  input  wire nsoc_phases_s I_PHASES,
  input  wire logic         I_DISABLE,
  output logic              O_START,
  output logic              O_TRIP,
  output logic              O_IRQ
);

  // --------------------------------------------------------------------
  // Constants and helpers
  // --------------------------------------------------------------------
  localparam int DW = $clog2(MS_CYCLES + 1);
  localparam logic [DW-1:0] MS_LAST = DW'(MS_CYCLES - 1);
  localparam logic [63:0] INC_SCALE =
    64'((64'd1 << `NSOC_ACC_FRAC) * 64'(SAMPLE_US)
        * 64'(`NSOC_MULT_UNIT) / 64'(`NSOC_US_PER_S));
  // Sine of 60 deg in Q15
  localparam logic signed [17:0] SIN60 = 18'sh0_6EDA;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  function automatic logic [15:0] clip(input logic [31:0] v,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
    if (v < 32'(lo))
      clip = lo;
    else if (v > 32'(hi))
      clip = hi;
    else
      clip = v[15:0];
  endfunction

  function automatic logic [4:0] msb_of(input logic [24:0] v);
    msb_of = 5'd0;
    for (int i = 0; i < 25; i++)
      if (v[i])
        msb_of = 5'(i);
  endfunction

  // --------------------------------------------------------------------
  // Registers and internal state
  // --------------------------------------------------------------------
  nsoc_mode_e   curve_mode_select;
  logic [15:0]  start_threshold_pct;
  logic [15:0]  definite_delay;
  logic [15:0]  inverse_min_delay;
  logic [15:0]  inverse_reset_delay;
  logic [15:0]  curve_time_multiplier;
  logic [1:0]   irq_status;
  logic [1:0]   irq_mask;
  logic         start_d;
  logic         trip_d;
  logic         wb_req;
  logic         wb_wr;
  logic [31:0]  rd_word;
  logic [31:0]  wr_word;
  logic [DW-1:0] ms_div;
  logic         ms_tick;
  logic [15:0]  run_ms;
  logic [15:0]  rst_ms;
  logic         active;
  logic         fixed;
  logic         inverse;
  logic         above;
  logic         drop;
  logic         next_trip;
  logic         acc_clr;
  logic signed [33:0] p_br;
  logic signed [33:0] p_bi;
  logic signed [33:0] p_cr;
  logic signed [33:0] p_ci;
  logic signed [19:0] seq_re;
  logic signed [19:0] seq_im;
  logic [40:0]  mag9;
  logic [23:0]  gs;
  logic [47:0]  gs9;
  nsoc_state_e  state;
  nsoc_curve_s  curve;
  logic [24:0]  r2;
  logic [24:0]  y;
  logic [25:0]  acc;
  logic [20:0]  sq_res;
  logic [20:0]  sq_cand;
  logic [20:0]  sq_next;
  logic [4:0]   sq_idx;
  logic [4:0]   lg_pos;
  logic [24:0]  lg_norm;
  logic [15:0]  lg_m;
  logic [31:0]  lg_sq;
  logic [20:0]  lg_corr;
  logic [20:0]  lg_q16;
  logic [24:0]  y_log;
  logic [25:0]  den_s;
  logic [24:0]  r2_new;
  logic [25:0]  inc;
  logic [26:0]  acc_sum;
  logic [63:0]  div_num;
  logic [63:0]  div_den;
  logic         div_go;
  logic [63:0]  div_rem;
  logic [63:0]  div_quo;
  logic [6:0]   div_cnt;
  logic         div_done;
  logic [64:0]  div_trial;

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wb_wr  = wb_req && I_WB_WE;

  always_comb
  begin
    case (I_WB_ADR)
      `NSOC_REG_CTRL:    rd_word = 32'(curve_mode_select);
      `NSOC_REG_START:   rd_word = 32'(start_threshold_pct);
      `NSOC_REG_DEFDLY:  rd_word = 32'(definite_delay);
      `NSOC_REG_MINDLY:  rd_word = 32'(inverse_min_delay);
      `NSOC_REG_RSTDLY:  rd_word = 32'(inverse_reset_delay);
      `NSOC_REG_MULT:    rd_word = 32'(curve_time_multiplier);
      `NSOC_REG_IRQ_ST:  rd_word = 32'(irq_status);
      `NSOC_REG_IRQ_MSK: rd_word = 32'(irq_mask);
      `NSOC_REG_STATE:   rd_word = 32'({O_TRIP, O_START});
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = merge(rd_word, I_WB_DAT, I_WB_SEL);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end
    else
    begin
      O_WB_ACK <= wb_req;
      O_WB_DAT <= (wb_req && !I_WB_WE) ? rd_word : 32'h0000_0000;
    end
  end

  // Settings are clipped into range, an unknown mode falls to MODE_OFF, so the timers never see nonsense
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      curve_mode_select     <= MODE_OFF;
      start_threshold_pct   <= `NSOC_PCT_RST;
      definite_delay        <= `NSOC_DLY_RST;
      inverse_min_delay     <= `NSOC_DLY_RST;
      inverse_reset_delay   <= `NSOC_DLY_RST;
      curve_time_multiplier <= `NSOC_MULT_RST;
      irq_mask              <= 2'h0;
    end
    else if (wb_wr)
    begin
      case (I_WB_ADR)
        `NSOC_REG_CTRL:
          curve_mode_select <= (wr_word > 32'(MODE_ANSI_LEI)) ?
                               MODE_OFF : nsoc_mode_e'(wr_word[3:0]);
        `NSOC_REG_START:
          start_threshold_pct <= clip(wr_word, `NSOC_PCT_MIN,
                                      `NSOC_PCT_MAX);
        `NSOC_REG_DEFDLY:
          definite_delay <= clip(wr_word, 16'h0000, `NSOC_DLY_MAX);
        `NSOC_REG_MINDLY:
          inverse_min_delay <= clip(wr_word, 16'h0000, `NSOC_DLY_MAX);
        `NSOC_REG_RSTDLY:
          inverse_reset_delay <= clip(wr_word, 16'h0000, `NSOC_DLY_MAX);
        `NSOC_REG_MULT:
          curve_time_multiplier <= clip(wr_word, `NSOC_MULT_MIN,
                                        `NSOC_MULT_MAX);
        `NSOC_REG_IRQ_MSK:
          irq_mask <= wr_word[1:0];
        default:
          irq_mask <= irq_mask;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupt: a new event wins over a write-one clear in the same cycle
  // --------------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      irq_status <= 2'h0;
      start_d    <= 1'b0;
      trip_d     <= 1'b0;
      O_IRQ      <= 1'b0;
    end
    else
    begin
      start_d <= O_START;
      trip_d  <= O_TRIP;
      irq_status <= (irq_status
                     & ~((wb_wr && I_WB_ADR == `NSOC_REG_IRQ_ST
                          && I_WB_SEL[0]) ? I_WB_DAT[1:0] : 2'h0))
                    | {O_TRIP & ~trip_d, O_START & ~start_d};
      O_IRQ <= |(irq_status & irq_mask);
    end
  end

  // --------------------------------------------------------------------
  // Negative sequence: 3*I2 = Ia + a^2*Ib + a*Ic
  // --------------------------------------------------------------------
  assign p_br = I_PHASES.b.re * SIN60;
  assign p_bi = I_PHASES.b.im * SIN60;
  assign p_cr = I_PHASES.c.re * SIN60;
  assign p_ci = I_PHASES.c.im * SIN60;
  assign seq_re = 20'(I_PHASES.a.re) - 20'(I_PHASES.b.re >>> 1)
                - 20'(I_PHASES.c.re >>> 1) + 20'(p_bi >>> 15)
                - 20'(p_ci >>> 15);
  assign seq_im = 20'(I_PHASES.a.im) - 20'(I_PHASES.b.im >>> 1)
                - 20'(I_PHASES.c.im >>> 1) - 20'(p_br >>> 15)
                + 20'(p_cr >>> 15);
  // Squared magnitude of 3*I2; the factor 9 moves to the threshold
  assign mag9 = 41'(seq_re * seq_re) + 41'(seq_im * seq_im);
  assign gs  = 24'(start_threshold_pct * PCT_CODE);
  assign gs9 = 48'(gs) * 48'(gs) * 48'd9;

  // --------------------------------------------------------------------
  // Pickup with a 0.95 drop-off ratio against chatter
  // --------------------------------------------------------------------
  assign active  = curve_mode_select != MODE_OFF && !I_DISABLE;
  assign fixed   = curve_mode_select == MODE_FIXED_DELAY;
  assign inverse = active && !fixed;
  assign above   = 48'(mag9) > gs9;
  assign drop    = 64'(mag9) * 64'(`NSOC_DROP_DEN)
                 < 64'(gs9) * 64'(`NSOC_DROP_NUM);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_START <= 1'b0;
    else if (!active)
      O_START <= 1'b0;
    else if (I_SAMPLE_EN && above)
      O_START <= 1'b1;
    else if (I_SAMPLE_EN && drop)
      O_START <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Millisecond timers
  // --------------------------------------------------------------------
  assign ms_tick = ms_div == MS_LAST;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      ms_div <= '0;
    else
      ms_div <= ms_tick ? '0 : ms_div + 1'b1;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      run_ms <= 16'h0000;
      rst_ms <= 16'h0000;
    end
    else
    begin
      if (!O_START)
        run_ms <= 16'h0000;
      else if (ms_tick && run_ms != 16'hFFFF)
        run_ms <= run_ms + 16'h0001;
      if (O_START || !active)
        rst_ms <= 16'h0000;
      else if (ms_tick && rst_ms != 16'hFFFF)
        rst_ms <= rst_ms + 16'h0001;
    end
  end

  assign acc_clr = !inverse
                || (!O_START && rst_ms >= inverse_reset_delay);

  assign next_trip = O_START && (fixed ?
    run_ms >= definite_delay :
    (acc >= `NSOC_ACC_ONE && run_ms >= inverse_min_delay));

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_TRIP <= 1'b0;
    else
      // Trip falls on the same edge as start, never lingers alone
      O_TRIP <= active && next_trip && !(I_SAMPLE_EN && drop);
  end

  // --------------------------------------------------------------------
  // Curve arithmetic
  // --------------------------------------------------------------------
  // Clamp the squared ratio to [1, 400]: at most twenty times pickup
  assign r2_new = (div_quo > 64'(`NSOC_R2_CAP)) ? `NSOC_R2_CAP :
                  (div_quo < 64'(`NSOC_ONE_Q16)) ? `NSOC_ONE_Q16 :
                  div_quo[24:0];

  // Alpha 0.02: r^0.02 - 1 ~ 0.01*ln(r2), log2 with a parabolic fix-up
  assign lg_pos  = msb_of(r2);
  assign lg_norm = r2 << (5'd24 - lg_pos);
  assign lg_m    = lg_norm[23:8];
  assign lg_sq   = (32'(lg_m) * 32'(lg_m)) >> 16;
  assign lg_corr = 21'((32'(lg_m) - lg_sq) * 32'(`NSOC_LOG_CORR) >> 5);
  assign lg_q16  = {5'(lg_pos - 5'd16), 16'h0000} + 21'(lg_m) + lg_corr;
  assign y_log   = 25'((32'(lg_q16) * 32'(`NSOC_LN2_ALPHA)) >> 16);

  assign sq_cand = sq_res | (21'd1 << sq_idx);
  assign sq_next = (42'(sq_cand) * 42'(sq_cand) <= {r2, 16'h0000})
                 ? sq_cand : sq_res;

  // Operate time is mult/100 * (k + c*y) / y; y = ratio^alpha - 1
  assign den_s = 26'(curve.k)
               + 26'((41'(curve.c) * 41'(y)) >> 16);
  assign inc = (div_quo > 64'(`NSOC_INC_MAX)) ? `NSOC_INC_MAX
             : div_quo[25:0];
  assign acc_sum = 27'(acc) + 27'(inc);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state   <= ST_IDLE;
      curve   <= '0;
      r2      <= `NSOC_ONE_Q16;
      y       <= '0;
      acc     <= '0;
      sq_res  <= '0;
      sq_idx  <= '0;
      div_num <= '0;
      div_den <= '0;
      div_go  <= 1'b0;
    end
    else
    begin
      div_go <= 1'b0;
      case (state)
        ST_IDLE:
          if (I_SAMPLE_EN && inverse && (above || (O_START && !drop)))
          begin
            curve   <= nsoc_curve_of(curve_mode_select);
            div_num <= 64'(mag9) << 16;
            div_den <= 64'(gs9);
            div_go  <= 1'b1;
            state   <= ST_RATIO;
          end
        ST_RATIO:
          if (div_done)
          begin
            r2     <= r2_new;
            sq_res <= '0;
            sq_idx <= 5'd20;
            state  <= ST_ROOT;
          end
        ST_ROOT:
          case (curve.alpha)
            ALPHA_2:
            begin
              y     <= r2 - `NSOC_ONE_Q16;
              state <= ST_CALC;
            end
            ALPHA_1:
            begin
              sq_res <= sq_next;
              sq_idx <= sq_idx - 5'd1;
              if (sq_idx == 5'd0)
              begin
                y     <= 25'(sq_next) - `NSOC_ONE_Q16;
                state <= ST_CALC;
              end
            end
            default:
            begin
              y     <= y_log;
              state <= ST_CALC;
            end
          endcase
        ST_CALC:
        begin
          div_num <= 64'(y) * INC_SCALE;
          div_den <= 64'(curve_time_multiplier) * 64'(den_s);
          div_go  <= 1'b1;
          state   <= ST_INC;
        end
        ST_INC:
          if (div_done)
          begin
            if (!acc_clr)
              acc <= (acc_sum > 27'(`NSOC_INC_MAX)) ? `NSOC_INC_MAX
                   : acc_sum[25:0];
            state <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
      if (acc_clr)
        acc <= '0;
    end
  end

  // --------------------------------------------------------------------
  // Shared restoring divider, 64 cycles per quotient
  // --------------------------------------------------------------------
  assign div_trial = {div_rem, div_quo[63]} - {1'b0, div_den};

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      div_rem  <= '0;
      div_quo  <= '0;
      div_cnt  <= '0;
      div_done <= 1'b0;
    end
    else
    begin
      div_done <= div_cnt == 7'd1;
      if (div_go)
      begin
        div_rem <= '0;
        div_quo <= div_num;
        div_cnt <= 7'd64;
      end
      else if (div_cnt != 7'd0)
      begin
        div_cnt <= div_cnt - 7'd1;
        if (!div_trial[64])
        begin
          div_rem <= div_trial[63:0];
          div_quo <= {div_quo[62:0], 1'b1};
        end
        else
        begin
          div_rem <= {div_rem[62:0], div_quo[63]};
          div_quo <= {div_quo[62:0], 1'b0};
        end
      end
    end
  end

endmodule
